// >>> hssm_pkg.sv
// shared constants and types for the high-side switch mode controller
package hssm_pkg;

  // ==========================================================================
  // clock and timing
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned STBY_TIME_US   = 1000;
  localparam int unsigned STBY_CYCLES    = STBY_TIME_US * CLK_MHZ;
  localparam int unsigned RETRY_TIME_US  = 1000;
  localparam int unsigned RETRY_CYCLES   = RETRY_TIME_US * CLK_MHZ;
  localparam int unsigned CNT_W          = 20;

  // ==========================================================================
  // register map
  localparam int unsigned AXI_AW         = 4;
  localparam logic [3:0]  ADDR_CTRL      = 4'h0;
  localparam logic [3:0]  ADDR_STATUS    = 4'h4;
  localparam int unsigned CTRL_W         = 2;
  localparam int unsigned CTRL_TEMP_BIT  = 0;
  localparam int unsigned CTRL_FLAG_BIT  = 1;
  localparam logic [1:0]  CTRL_RESET     = 2'h0;
  localparam int unsigned ST_STATE_LSB   = 0;
  localparam int unsigned ST_GATE_BIT    = 3;
  localparam int unsigned ST_FDET_BIT    = 4;
  localparam int unsigned ST_DIAGF_BIT   = 5;
  localparam int unsigned ST_GND_BIT     = 6;
  localparam int unsigned ST_RETRY_BIT   = 7;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // ==========================================================================
  // sense mux selections
  localparam logic [1:0]  SENSE_CURRENT  = 2'h0;
  localparam logic [1:0]  SENSE_TEMP     = 2'h1;
  localparam logic [1:0]  SENSE_FAULT    = 2'h2;

  // ==========================================================================
  // types
  typedef enum logic [2:0] {
    ST_OFF,
    ST_STANDBY,
    ST_STBY_DELAY,
    ST_DIAG,
    ST_ACTIVE,
    ST_FAULT
  } hssm_state_e;

  typedef struct packed {
    logic switch_on;
    logic diag;
    logic hold;
    logic thermal;
    logic current_limit_set;
    logic gnd_lost;
    logic open_load;
  } hssm_in_s;

  localparam int unsigned IN_W = $bits(hssm_in_s);

endpackage : hssm_pkg

// >>> hssm_sync.sv
// two-stage synchroniser for a group of pin levels
`timescale 1ns/1ps
`default_nettype none

module hssm_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             sys_clk_in,  // system clock
  input  wire logic             reset_n_in,  // async reset, active low
  input  wire logic [WIDTH-1:0] async_in,    // levels from pins
  output logic      [WIDTH-1:0] sync_out     // levels in clock domain
);

  // ==========================================================================
  // per-bit flop pair; the first stage feeds only the second
  generate
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_bit
      logic meta;
      always_ff @(posedge sys_clk_in or negedge reset_n_in)
      begin
        if (!reset_n_in)
        begin
          meta        <= 1'b0;
          sync_out[i] <= 1'b0;
        end
        else
        begin
          meta        <= async_in[i];
          sync_out[i] <= meta;
        end
      end
    end
  endgenerate

endmodule : hssm_sync
`default_nettype wire

// >>> hssm_top.sv
// operating-state controller of a smart high-side switch, axi4-lite status
`timescale 1ns/1ps
`default_nettype none

module hssm_top #(
  parameter int unsigned STBY_CYCLES  = hssm_pkg::STBY_CYCLES,
  parameter int unsigned RETRY_CYCLES = hssm_pkg::RETRY_CYCLES
) (
  input  wire logic        sys_clk_in,             // 250 MHz clock
  input  wire logic        reset_n_in,             // async reset, low
  input  wire logic        switch_on_request_in,   // pin: switch enable
  input  wire logic        diag_request_in,        // pin: diag enable
  input  wire logic        fault_hold_select_in,   // pin: latch faults
  input  wire logic        thermal_shutdown_in,    // pin: overtemperature
  input  wire logic        current_limit_in,       // pin: current limit
  input  wire logic        ground_lost_in,         // pin: ground lost
  input  wire logic        open_load_in,           // pin: vout above vol
  output logic             switch_gate_out,        // output switch on
  output logic [1:0]       sense_output_mode_out,  // sense mux select
  output logic             sense_output_oe_n_out,  // sense drive, low
  output logic             fault_flag_out,         // open-drain level
  output logic             fault_flag_oe_n_out,    // flag drive, low
  input  wire logic [3:0]  s_axi_awaddr,           // write address
  input  wire logic        s_axi_awvalid,          // write addr valid
  output logic             s_axi_awready,          // write addr ready
  input  wire logic [31:0] s_axi_wdata,            // write data
  input  wire logic [3:0]  s_axi_wstrb,            // write strobes
  input  wire logic        s_axi_wvalid,           // write data valid
  output logic             s_axi_wready,           // write data ready
  output logic [1:0]       s_axi_bresp,            // write response
  output logic             s_axi_bvalid,           // write resp valid
  input  wire logic        s_axi_bready,           // write resp ready
  input  wire logic [3:0]  s_axi_araddr,           // read address
  input  wire logic        s_axi_arvalid,          // read addr valid
  output logic             s_axi_arready,          // read addr ready
  output logic [31:0]      s_axi_rdata,            // read data
  output logic [1:0]       s_axi_rresp,            // read response
  output logic             s_axi_rvalid,           // read data valid
  input  wire logic        s_axi_rready            // read data ready
);

  localparam int unsigned CW = hssm_pkg::CNT_W;
  localparam logic [CW-1:0] STBY_LAST  = CW'(STBY_CYCLES - 1);
  localparam logic [CW-1:0] RETRY_LAST = CW'(RETRY_CYCLES - 1);

  // ==========================================================================
  // pin synchronisers
  hssm_pkg::hssm_in_s   pin_raw;
  hssm_pkg::hssm_in_s   pins;
  logic [hssm_pkg::IN_W-1:0] pins_bits;

  always_comb
  begin
    pin_raw.switch_on = switch_on_request_in;
    pin_raw.diag      = diag_request_in;
    pin_raw.hold      = fault_hold_select_in;
    pin_raw.thermal   = thermal_shutdown_in;
    pin_raw.current_limit_set      = current_limit_in;
    pin_raw.gnd_lost  = ground_lost_in;
    pin_raw.open_load = open_load_in;
  end

  hssm_sync #(
    .WIDTH      (hssm_pkg::IN_W)
  ) u_sync (
    .sys_clk_in (sys_clk_in),
    .reset_n_in (reset_n_in),
    .async_in   (pin_raw),
    .sync_out   (pins_bits)
  );

  assign pins = hssm_pkg::hssm_in_s'(pins_bits);

  // ==========================================================================
  // state machine
  hssm_pkg::hssm_state_e state;
  hssm_pkg::hssm_state_e next_state;
  hssm_pkg::hssm_state_e request_state;
  logic [CW-1:0]         stby_cnt;
  logic [CW-1:0]         retry_cnt;
  logic                  fault_event;
  logic                  stby_done;
  logic                  retry_done;

  // inverse current has no input here: it changes nothing in the sequence
  assign fault_event = pins.thermal | pins.current_limit_set;
  assign stby_done   = (stby_cnt == STBY_LAST);
  assign retry_done  = (retry_cnt == RETRY_LAST);

  // where the request pins point when no timer or fault holds the machine
  always_comb
  begin
    if (pins.switch_on)
      request_state = hssm_pkg::ST_ACTIVE;
    else if (pins.diag)
      request_state = hssm_pkg::ST_DIAG;
    else
      request_state = hssm_pkg::ST_STBY_DELAY;
  end

  always_comb
  begin
    next_state = state;
    case (state)
      hssm_pkg::ST_OFF:
        next_state = request_state;
      hssm_pkg::ST_STBY_DELAY:
        if (pins.switch_on || pins.diag)
          next_state = request_state;
        else if (stby_done)
          next_state = hssm_pkg::ST_STANDBY;
      hssm_pkg::ST_STANDBY:
        if (pins.switch_on || pins.diag)
          next_state = request_state;
      hssm_pkg::ST_DIAG:
        next_state = request_state;
      hssm_pkg::ST_ACTIVE:
        // diag changes alone never leave active
        if (!pins.switch_on)
          next_state = request_state;
      hssm_pkg::ST_FAULT:
        if (!fault_event && !pins.hold && retry_done)
          next_state = request_state;
      default:
        next_state = hssm_pkg::ST_OFF;
    endcase
    if (fault_event)
      next_state = hssm_pkg::ST_FAULT;
    // ground loss drops the state machine to off, even from fault; ctrl keeps its value
    if (pins.gnd_lost)
      next_state = hssm_pkg::ST_OFF;
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      state <= hssm_pkg::ST_OFF;
    else
      state <= next_state;
  end

  // standby delay timer restarts on every entry
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      stby_cnt <= '0;
    else if (next_state != hssm_pkg::ST_STBY_DELAY)
      stby_cnt <= '0;
    else if (state == hssm_pkg::ST_STBY_DELAY && !stby_done)
      stby_cnt <= stby_cnt + 1'b1;
  end

  // retry timer starts on entry to fault and then saturates
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      retry_cnt <= '0;
    else if (state != hssm_pkg::ST_FAULT)
      retry_cnt <= '0;
    else if (!retry_done)
      retry_cnt <= retry_cnt + 1'b1;
  end

  // switch follows the state; re-enable after fault only through active
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      switch_gate_out <= 1'b0;
    else
      switch_gate_out <= (next_state == hssm_pkg::ST_ACTIVE) &&
                         !pins.gnd_lost;
  end

  // ==========================================================================
  // diagnostics and sense mux
  logic [hssm_pkg::CTRL_W-1:0] ctrl;
  logic                        diag_fault;
  logic                        fault_detect;
  logic                        detect_en;

  // open-load tracks the present level, so both clearing edges are implied:
  // a falling diag or rising enable removes the detect window itself
  assign detect_en = pins.diag && !pins.switch_on &&
                     (state == hssm_pkg::ST_DIAG);

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      diag_fault <= 1'b0;
    else
      diag_fault <= detect_en && pins.open_load;
  end

  assign fault_detect = (state == hssm_pkg::ST_FAULT) || pins.current_limit_set ||
                        diag_fault;

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      sense_output_oe_n_out <= 1'b1;
      sense_output_mode_out <= hssm_pkg::SENSE_CURRENT;
      fault_flag_oe_n_out   <= 1'b1;
    end
    else
    begin
      sense_output_oe_n_out <= !pins.diag;
      if (ctrl[hssm_pkg::CTRL_TEMP_BIT] && !ctrl[hssm_pkg::CTRL_FLAG_BIT])
        sense_output_mode_out <= hssm_pkg::SENSE_TEMP;
      else if (fault_detect)
        sense_output_mode_out <= hssm_pkg::SENSE_FAULT;
      else
        sense_output_mode_out <= hssm_pkg::SENSE_CURRENT;
      fault_flag_oe_n_out   <= !(ctrl[hssm_pkg::CTRL_FLAG_BIT] &&
                                 pins.diag && fault_detect);
    end
  end

  // open drain: only ever pulls low
  assign fault_flag_out = 1'b0;

  // ==========================================================================
  // axi4-lite slave
  logic        aw_held;
  logic [3:0]  aw_addr;
  logic        w_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic [31:0] status_word;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_comb
  begin
    status_word = '0;
    status_word[hssm_pkg::ST_STATE_LSB +: 3] = state;
    status_word[hssm_pkg::ST_GATE_BIT]       = switch_gate_out;
    status_word[hssm_pkg::ST_FDET_BIT]       = fault_detect;
    status_word[hssm_pkg::ST_DIAGF_BIT]      = diag_fault;
    status_word[hssm_pkg::ST_GND_BIT]        = pins.gnd_lost;
    status_word[hssm_pkg::ST_RETRY_BIT]      = (state == hssm_pkg::ST_FAULT)
                                               && !retry_done;
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      aw_held <= 1'b0;
      aw_addr <= 4'h0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
    else if (aw_held && w_held)
      aw_held <= 1'b0;
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      w_held <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
    else if (aw_held && w_held)
      w_held <= 1'b0;
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      ctrl         <= hssm_pkg::CTRL_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= hssm_pkg::RESP_OKAY;
    end
    else if (aw_held && w_held)
    begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr == hssm_pkg::ADDR_CTRL)
      begin
        s_axi_bresp <= hssm_pkg::RESP_OKAY;
        if (w_strb[0])
          ctrl <= w_data[hssm_pkg::CTRL_W-1:0];
      end
      else if (aw_addr == hssm_pkg::ADDR_STATUS)
        s_axi_bresp <= hssm_pkg::RESP_OKAY;
      else
        s_axi_bresp <= hssm_pkg::RESP_SLVERR;
    end
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= hssm_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      if (s_axi_araddr == hssm_pkg::ADDR_CTRL)
      begin
        s_axi_rdata <= {{(32 - hssm_pkg::CTRL_W){1'b0}}, ctrl};
        s_axi_rresp <= hssm_pkg::RESP_OKAY;
      end
      else if (s_axi_araddr == hssm_pkg::ADDR_STATUS)
      begin
        s_axi_rdata <= status_word;
        s_axi_rresp <= hssm_pkg::RESP_OKAY;
      end
      else
      begin
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= hssm_pkg::RESP_SLVERR;
      end
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ==========================================================================
  // assertions
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_fault_left;
    (state == hssm_pkg::ST_FAULT) ##1
    (state != hssm_pkg::ST_FAULT && state != hssm_pkg::ST_OFF);
  endsequence

  sequence s_stby_reached;
    (state == hssm_pkg::ST_STBY_DELAY) ##1 (state == hssm_pkg::ST_STANDBY);
  endsequence

  a_stby_entry: assert property (
    (!pins.gnd_lost && !fault_event && !pins.switch_on && !pins.diag &&
     (state == hssm_pkg::ST_DIAG || state == hssm_pkg::ST_ACTIVE))
    |=> (state == hssm_pkg::ST_STBY_DELAY) && (stby_cnt == '0))
    else $error("standby delay not entered with both requests low");

  a_stby_timed: assert property (
    s_stby_reached |-> ($past(stby_cnt) == STBY_LAST) &&
                       !$past(pins.switch_on) && !$past(pins.diag))
    else $error("standby reached before the full delay");

  a_standby_quiet: assert property (
    (state == hssm_pkg::ST_STANDBY) |-> !diag_fault && !switch_gate_out)
    else $error("activity in standby");

  a_diag_off: assert property (
    (state == hssm_pkg::ST_DIAG) |-> !switch_gate_out)
    else $error("switch on in diagnostic state");

  a_active_on: assert property (
    (state == hssm_pkg::ST_ACTIVE) |-> switch_gate_out)
    else $error("switch off in active state");

  a_active_diag: assert property (
    (state == hssm_pkg::ST_ACTIVE && pins.switch_on && !fault_event &&
     !pins.gnd_lost) |=> (state == hssm_pkg::ST_ACTIVE))
    else $error("diag change left active state");

  a_fault_entry: assert property (
    (fault_event && !pins.gnd_lost)
    |=> (state == hssm_pkg::ST_FAULT) && !switch_gate_out)
    else $error("shutdown event did not enter fault");

  a_fault_exit: assert property (
    s_fault_left |-> $past(retry_done) && !$past(pins.hold) &&
                     !$past(fault_event))
    else $error("fault left too early");

  a_retry_on: assert property (
    s_fault_left ##0 $past(pins.switch_on)
    |-> (state == hssm_pkg::ST_ACTIVE) && switch_gate_out)
    else $error("no re-enable after fault");

  a_retry_off: assert property (
    s_fault_left ##0 !$past(pins.switch_on) |-> !switch_gate_out)
    else $error("switch on after fault with enable low");

  a_gnd_off: assert property (
    pins.gnd_lost |=> !switch_gate_out && (state == hssm_pkg::ST_OFF))
    else $error("switch not off on ground loss");

  a_gnd_resume: assert property (
    (state == hssm_pkg::ST_OFF && !pins.gnd_lost && !fault_event)
    |=> (state != hssm_pkg::ST_OFF))
    else $error("no resume after ground restored");

  a_flag_drive: assert property (
    !fault_flag_oe_n_out |-> $past(ctrl[hssm_pkg::CTRL_FLAG_BIT]) &&
                            $past(pins.diag))
    else $error("fault flag driven without cause");

  a_detect_window: assert property (
    diag_fault |-> $past(pins.diag) && !$past(pins.switch_on))
    else $error("open load reported outside diagnostics");

  a_diag_clear: assert property (
    ($fell(pins.diag) || $rose(pins.switch_on)) |=> !diag_fault)
    else $error("diag fault not cleared");

  a_sense_hiz: assert property (
    !$past(pins.diag) |-> sense_output_oe_n_out)
    else $error("sense driven with diag low");

  a_wake_direct: assert property (
    (state == hssm_pkg::ST_STANDBY && pins.diag && !pins.switch_on &&
     !fault_event && !pins.gnd_lost) |=> (state == hssm_pkg::ST_DIAG))
    else $error("standby did not wake into diagnostics");

endmodule : hssm_top
`default_nettype wire

// >>> hssm_mcu_model.sv
// host side model: pulled-up fault flag line and sense adc input
`timescale 1ns/1ps
`default_nettype none

module hssm_mcu_model (
  input  wire logic fault_flag_in,      // flag level from device
  input  wire logic fault_flag_oe_n_in, // flag drive, low = driven
  input  wire logic sense_oe_n_in,      // sense drive, low = driven
  output logic      flag_line_out,      // resolved flag wire
  output logic      sense_driven_out    // adc input sees a source
);
  // ==========================================================================
  // wire resolution
  // external pull-up wins whenever the open-drain flag is released
  assign flag_line_out = fault_flag_oe_n_in ? 1'b1 : fault_flag_in;
  // the adc cannot tell a released line from a driven one without this
  assign sense_driven_out = !sense_oe_n_in;
endmodule : hssm_mcu_model
`default_nettype wire

// >>> tb_top.sv
// self-checking bench for the high-side switch mode controller
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  // ==========================================================================
  // signals
  localparam int unsigned CYC = 16;
  logic               sys_clk_in;
  logic               reset_n_in;
  hssm_pkg::hssm_in_s pin;
  logic [3:0]         s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0]        s_axi_wdata, s_axi_rdata, status, d;
  logic [1:0]         s_axi_bresp, s_axi_rresp, sense_mode, r;
  logic               s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic               s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic               s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic               s_axi_rready, switch_gate_out, sense_output_oe_n_out;
  logic               fault_flag_out, fault_flag_oe_n_out;
  logic               flag_line, sense_driven;
  int unsigned        failures, check_count, cycles;

  hssm_top #(.STBY_CYCLES(CYC), .RETRY_CYCLES(CYC)) i_hssm_top (
    .sys_clk_in, .reset_n_in,
    .switch_on_request_in(pin.switch_on), .diag_request_in(pin.diag),
    .fault_hold_select_in(pin.hold), .thermal_shutdown_in(pin.thermal),
    .current_limit_in(pin.current_limit_set), .ground_lost_in(pin.gnd_lost),
    .open_load_in(pin.open_load), .switch_gate_out,
    .sense_output_mode_out(sense_mode), .sense_output_oe_n_out,
    .fault_flag_out, .fault_flag_oe_n_out,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);

  hssm_mcu_model i_hssm_mcu_model (
    .fault_flag_in(fault_flag_out), .fault_flag_oe_n_in(fault_flag_oe_n_out),
    .sense_oe_n_in(sense_output_oe_n_out),
    .flag_line_out(flag_line), .sense_driven_out(sense_driven));

  // ==========================================================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wrap_up();
    $display("failures %0d checks %0d", failures, check_count);
    if (failures == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  // handshakes are sampled at the rising edge, before the slave's updates
  // land; each channel is released right after the edge that takes it
  task automatic axi_write(input logic [3:0] a, input logic [31:0] v,
                           output logic [1:0] resp);
    @(posedge sys_clk_in);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_wstrb   <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    forever
    begin
      @(posedge sys_clk_in);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask : axi_write

  task automatic axi_read(input logic [3:0] a, output logic [31:0] v,
                          output logic [1:0] resp);
    @(posedge sys_clk_in);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    forever
    begin
      @(posedge sys_clk_in);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        v    = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask : axi_read

  // pin order: on, diag, hold, thermal, current_limit_set, gnd lost, open load
  task automatic step(input logic [6:0] v, input int unsigned n);
    @(posedge sys_clk_in);
    pin <= v;
    repeat (n) @(posedge sys_clk_in);
  endtask : step

  task automatic expect_st(input logic [2:0] st, input logic g);
    logic [1:0] rs;
    axi_read(hssm_pkg::ADDR_STATUS, status, rs);
    chk("state", st, status[2:0]);
    chk("gate", g, switch_gate_out);
  endtask : expect_st

  // ==========================================================================
  // clock, watchdog and test sequence
  initial
  begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end

  always @(posedge sys_clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      failures++;
      wrap_up();
    end
  end

  initial
  begin
    {failures, check_count, cycles} = '0;
    pin = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    reset_n_in = 1'b0;
    @(posedge sys_clk_in);
    #1;
    chk("rst_gate", 1'b0, switch_gate_out);
    chk("rst_flag", 1'b1, flag_line);
    chk("rst_sense", 1'b0, sense_driven);
    @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    axi_read(hssm_pkg::ADDR_CTRL, d, r);
    chk("ctrl_reset", 32'h0, d);
    axi_read(4'h8, d, r);
    chk("unmapped_resp", hssm_pkg::RESP_SLVERR, r);
    chk("unmapped_data", 32'h0, d);
    axi_write(hssm_pkg::ADDR_STATUS, 32'hff, r);
    chk("status_wr_resp", hssm_pkg::RESP_OKAY, r);
    axi_write(4'hc, 32'h3, r);
    chk("unmapped_wr", hssm_pkg::RESP_SLVERR, r);
    step(7'h00, CYC + 8);
    expect_st(hssm_pkg::ST_STANDBY, 1'b0);
    chk("stby_sense", 1'b0, sense_driven);
    step(7'h20, 6);
    expect_st(hssm_pkg::ST_DIAG, 1'b0);
    chk("diag_sense", 1'b1, sense_driven);
    chk("mode_cur", hssm_pkg::SENSE_CURRENT, sense_mode);
    axi_write(hssm_pkg::ADDR_CTRL, 32'h2, r);
    chk("ctrl_wr_resp", hssm_pkg::RESP_OKAY, r);
    step(7'h21, 6);
    expect_st(hssm_pkg::ST_DIAG, 1'b0);
    chk("open_load", 1'b1, status[5]);
    chk("flag_low", 1'b0, flag_line);
    chk("mode_fault", hssm_pkg::SENSE_FAULT, sense_mode);
    step(7'h01, 6);
    expect_st(hssm_pkg::ST_STBY_DELAY, 1'b0);
    chk("diag_clear", 1'b0, status[5]);
    chk("flag_free", 1'b1, flag_line);
    chk("sense_off", 1'b0, sense_driven);
    step(7'h41, 6);
    expect_st(hssm_pkg::ST_ACTIVE, 1'b1);
    step(7'h61, 6);
    expect_st(hssm_pkg::ST_ACTIVE, 1'b1);
    chk("no_ol_active", 1'b0, status[5]);
    step(7'h40, 6);
    expect_st(hssm_pkg::ST_ACTIVE, 1'b1);
    step(7'h58, 6);
    expect_st(hssm_pkg::ST_FAULT, 1'b0);
    step(7'h50, 2 * CYC);
    expect_st(hssm_pkg::ST_FAULT, 1'b0);
    step(7'h40, 6);
    expect_st(hssm_pkg::ST_ACTIVE, 1'b1);
    step(7'h64, 6);
    expect_st(hssm_pkg::ST_FAULT, 1'b0);
    chk("flag_fault", 1'b0, flag_line);
    chk("mode_shut", hssm_pkg::SENSE_FAULT, sense_mode);
    step(7'h20, 2 * CYC);
    expect_st(hssm_pkg::ST_DIAG, 1'b0);
    step(7'h40, 6);
    expect_st(hssm_pkg::ST_ACTIVE, 1'b1);
    step(7'h42, 6);
    expect_st(hssm_pkg::ST_OFF, 1'b0);
    step(7'h40, 6);
    expect_st(hssm_pkg::ST_ACTIVE, 1'b1);
    // switch is off before ground goes away
    step(7'h20, 6);
    expect_st(hssm_pkg::ST_DIAG, 1'b0);
    step(7'h22, 6);
    expect_st(hssm_pkg::ST_OFF, 1'b0);
    step(7'h20, 6);
    expect_st(hssm_pkg::ST_DIAG, 1'b0);
    axi_write(hssm_pkg::ADDR_CTRL, 32'h1, r);
    step(7'h20, 4);
    chk("mode_temp", hssm_pkg::SENSE_TEMP, sense_mode);
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
